// *** verilog/wdt_pkg.sv ***
// constants, types and helpers shared by the reset and watchdog block
package wdt_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h34;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h40;
    localparam logic [7:0] ADDR_ANALOG_REF = 8'h44;

    // ****************************************
    // reset cause flag positions and reset value
    // ****************************************
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_BOD = 2;
    localparam int CAUSE_WDT = 3;
    localparam logic [3:0] CAUSE_RESET = 4'h1;

    // ****************************************
    // watchdog control field positions
    // ****************************************
    localparam int WC_IRQ_FLAG = 7;
    localparam int WC_IRQ_EN = 6;
    localparam int WC_PERIOD_HI = 5;
    localparam int WC_CHANGE_EN = 4;
    localparam int WC_ENABLE = 3;
    localparam int WC_PERIOD_LO_TOP = 2;

    // ****************************************
    // analog reference control field positions
    // ****************************************
    localparam int AR_COMP_BANDGAP = 0;
    localparam int AR_ADC_EN = 1;

    // ****************************************
    // bus constants
    // ****************************************
    localparam int TRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
    localparam int WDT_CNT_W = 20;
    localparam logic [WDT_CNT_W:0] WDT_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] TIMEOUT_CODE_MAX = 4'h9;
    localparam logic [3:0] PERIOD_RESET = 4'h0;

    // ****************************************
    // reset sequencer phases
    // ****************************************
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10,
        ST_WDT_PULSE = 2'b11
    } phase_type;

    // last count of a period; reserved codes fall back to the longest
    function automatic logic [WDT_CNT_W-1:0] timeout_last(input logic [3:0] code);
        logic [WDT_CNT_W:0] cycles;
        logic [3:0] sel;
        sel = (code > TIMEOUT_CODE_MAX) ? TIMEOUT_CODE_MAX : code;
        cycles = WDT_BASE_CYCLES << sel;
        return WDT_CNT_W'(cycles - 1'b1);
    endfunction

endpackage

// *** verilog/reset_link_if.sv ***
// signals between the reset front end and the watchdog core
`timescale 1ns/1ps
`default_nettype none
interface reset_link_if;
    logic core_reset_req;
    logic pin_req;
    logic bod_low;
    logic osc_tick;
    logic core_reset;

    modport front (
        input core_reset_req,
        output pin_req,
        output bod_low,
        output osc_tick,
        output core_reset
    );

    modport core (
        output core_reset_req,
        input pin_req,
        input bod_low,
        input osc_tick,
        input core_reset
    );
endinterface
`default_nettype wire

// *** verilog/reset_front.sv ***
// pin synchronisers and the asynchronously asserted processor reset flop
`timescale 1ns/1ps
`default_nettype none
module reset_front (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic reset_pin_n,
    input wire logic pin_reset_enable,
    input wire logic brownout_low,
    input wire logic watchdog_osc,
    reset_link_if.front lk
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0] pin_ok;
        logic [1:0] brownout_detector;
        logic [2:0] osc;
        logic core_reset;
    } front_type;

    localparam front_type FRONT_RESET = '{
        pin_ok: 2'h0,
        brownout_detector: 2'h0,
        osc: 3'h0,
        core_reset: 1'b1
    };

    front_type r_reg;
    front_type r_next;
    logic arst_n;

    // RULE_01: pin asserts reset without clock
    assign arst_n = hresetn & (reset_pin_n | ~pin_reset_enable);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        r_next = r_reg;
        // RULE_25: two-flop synchronisers
        r_next.pin_ok = {r_reg.pin_ok[0], 1'b1};
        r_next.brownout_detector = {r_reg.brownout_detector[0], brownout_low};
        r_next.osc = {r_reg.osc[1:0], watchdog_osc};
        r_next.core_reset = lk.core_reset_req;
    end

    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= FRONT_RESET;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign lk.pin_req = ~r_reg.pin_ok[1];
    assign lk.bod_low = r_reg.brownout_detector[1];
    // RULE_05: one tick per oscillator rising edge
    assign lk.osc_tick = r_reg.osc[1] & ~r_reg.osc[2];
    assign lk.core_reset = r_reg.core_reset;

endmodule
`default_nettype wire

// *** verilog/watchdog_and_reset_control.sv ***
// watchdog timer, reset sequencing and reset cause flags
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: enabled low reset pin resets, clock optional
// RULE_02: pin release runs start-up delay first
// RULE_03: brown-out resets at once, delayed release
// RULE_04: watchdog reset pulse one cycle, then delay
// RULE_05: watchdog counts dedicated 128 kHz oscillator
// RULE_06: restart, disable or chip reset clear counter
// RULE_07: ten periods; expiry resets the processor
// RULE_08: time-out may raise interrupt instead
// RULE_09: level one starts disabled, enable free
// RULE_10: level one disable needs timed two writes
// RULE_11: level two always runs, enable reads one
// RULE_12: level two period change needs timed writes
// RULE_13: cause register upper nibble reads zero
// RULE_14: watchdog flag sets, clears by zero write
// RULE_15: brown-out flag sets, clears by zero write
// RULE_16: pin flag sets, clears by zero write
// RULE_17: power-on flag cleared only by software
// RULE_18: software reads then clears cause flags early
// RULE_19: bandgap on for detector, comparator or converter
// RULE_20: change enable self-clears after four cycles
// RULE_21: interrupt time-out clears interrupt enable when reset also enabled
// RULE_22: level one enable forced while watchdog flag
// RULE_23: period codes zero..nine, 2K doubling cycles
// RULE_24: start-up delay is a static input
// RULE_25: asynchronous inputs synchronised before use
module watchdog_and_reset_control #(
    parameter int DELAY_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic reset_pin_n,
    input wire logic pin_reset_enable,
    input wire logic brownout_low,
    input wire logic brownout_detector_enable,
    input wire logic watchdog_osc,
    input wire logic watchdog_safety_fuse,
    input wire logic [DELAY_W-1:0] startup_delay_period,
    input wire logic watchdog_restart_instruction,
    input wire logic watchdog_irq_ack,
    output logic processor_reset,
    output logic watchdog_irq,
    output logic bandgap_enable
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (DELAY_W < 1 || DELAY_W > 32) begin : g_bad_width
        $error("DELAY_W must lie between 1 and 32");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        wdt_pkg::phase_type state;
        logic [DELAY_W-1:0] delay_cnt;
        logic [wdt_pkg::WDT_CNT_W-1:0] wdt_cnt;
        logic pin_prev;
        logic bod_prev;
        logic watchdog_interrupt_enable_bit;
        logic wde_bit;
        logic [3:0] period;
        logic [2:0] win_cnt;
        logic irq_flag;
        logic [3:0] cause;
        logic comparator_bandgap_select;
        logic adc_en;
        logic wr_pend;
        logic [wdt_pkg::REG_ADDR_W-1:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic bandgap;
    } core_type;

    localparam core_type CORE_RESET = '{
        state: wdt_pkg::ST_RESET,
        delay_cnt: '0,
        wdt_cnt: '0,
        pin_prev: 1'b1,
        bod_prev: 1'b1,
        watchdog_interrupt_enable_bit: 1'b0,
        wde_bit: 1'b0,
        period: wdt_pkg::PERIOD_RESET,
        win_cnt: 3'h0,
        irq_flag: 1'b0,
        cause: wdt_pkg::CAUSE_RESET,
        comparator_bandgap_select: 1'b0,
        adc_en: 1'b0,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h0000_0000,
        ready: 1'b1,
        bandgap: 1'b0
    };

    core_type r_reg;
    core_type r_next;

    reset_link_if lk ();

    reset_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .reset_pin_n(reset_pin_n),
        .pin_reset_enable(pin_reset_enable),
        .brownout_low(brownout_low),
        .watchdog_osc(watchdog_osc),
        .lk(lk)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic bod_req;
        logic req;
        logic enabled;
        logic running;
        logic timeout;
        logic wdt_fire;
        logic window;
        logic open_seq;
        logic [7:0] wd;
        logic [3:0] new_period;
        logic rd_en;
        bod_req = 1'b0;
        req = 1'b0;
        enabled = 1'b0;
        running = 1'b0;
        timeout = 1'b0;
        wdt_fire = 1'b0;
        window = 1'b0;
        open_seq = 1'b0;
        wd = 8'h00;
        new_period = 4'h0;
        rd_en = 1'b0;
        r_next = r_reg;
        r_next.ready = 1'b1;

        // RULE_03: detector gated by its enable
        bod_req = brownout_detector_enable & lk.bod_low;
        req = lk.pin_req | bod_req;

        // ****************************************
        // change window countdown
        // ****************************************
        // RULE_20: window closes four cycles later
        window = (r_reg.win_cnt != 3'h0);
        if (window) begin
            r_next.win_cnt = r_reg.win_cnt - 3'h1;
        end

        // ****************************************
        // register writes in the data phase
        // ****************************************
        wd = hwdata[7:0];
        new_period = {wd[wdt_pkg::WC_PERIOD_HI], wd[wdt_pkg::WC_PERIOD_LO_TOP:0]};
        open_seq = wd[wdt_pkg::WC_CHANGE_EN] & wd[wdt_pkg::WC_ENABLE];
        if (r_reg.wr_pend) begin
            if (r_reg.wr_addr == wdt_pkg::ADDR_RESET_CAUSE) begin
                // RULE_17: zero write clears, one keeps
                r_next.cause = r_reg.cause & wd[3:0];
            end else if (r_reg.wr_addr == wdt_pkg::ADDR_WDT_CTRL) begin
                if (wd[wdt_pkg::WC_IRQ_FLAG]) begin
                    r_next.irq_flag = 1'b0;
                end
                r_next.watchdog_interrupt_enable_bit = wd[wdt_pkg::WC_IRQ_EN];
                if (watchdog_safety_fuse) begin
                    // RULE_12: period only via timed sequence
                    if (open_seq) begin
                        r_next.win_cnt = wdt_pkg::CHANGE_WINDOW_CYCLES;
                    end else if (window && !wd[wdt_pkg::WC_CHANGE_EN]) begin
                        r_next.period = new_period;
                        r_next.win_cnt = 3'h0;
                    end
                end else begin
                    // RULE_09: free enable and period
                    r_next.period = new_period;
                    if (open_seq) begin
                        r_next.wde_bit = 1'b1;
                        r_next.win_cnt = wdt_pkg::CHANGE_WINDOW_CYCLES;
                    end else if (wd[wdt_pkg::WC_ENABLE]) begin
                        r_next.wde_bit = 1'b1;
                        if (window && !wd[wdt_pkg::WC_CHANGE_EN]) begin
                            r_next.win_cnt = 3'h0;
                        end
                    end else if (window && !wd[wdt_pkg::WC_CHANGE_EN]) begin
                        // RULE_10: disable only inside window
                        r_next.wde_bit = 1'b0;
                        r_next.win_cnt = 3'h0;
                    end
                end
            end else if (r_reg.wr_addr == wdt_pkg::ADDR_ANALOG_REF) begin
                r_next.comparator_bandgap_select = wd[wdt_pkg::AR_COMP_BANDGAP];
                r_next.adc_en = wd[wdt_pkg::AR_ADC_EN];
            end
        end

        // ****************************************
        // watchdog counter
        // ****************************************
        // RULE_22: watchdog flag forces enable
        // RULE_11: fuse keeps the watchdog running
        enabled = watchdog_safety_fuse | r_reg.cause[wdt_pkg::CAUSE_WDT] | r_reg.wde_bit;
        running = enabled | r_reg.watchdog_interrupt_enable_bit;
        if (r_reg.state != wdt_pkg::ST_RUN || !running || watchdog_restart_instruction) begin
            // RULE_06: counter cleared
            r_next.wdt_cnt = '0;
        end else if (lk.osc_tick) begin
            // RULE_23: period from code
            if (r_reg.wdt_cnt == wdt_pkg::timeout_last(r_reg.period)) begin
                r_next.wdt_cnt = '0;
                timeout = 1'b1;
            end else begin
                r_next.wdt_cnt = r_reg.wdt_cnt + 1'b1;
            end
        end

        if (watchdog_irq_ack) begin
            r_next.irq_flag = 1'b0;
        end
        if (timeout) begin
            if (r_reg.watchdog_interrupt_enable_bit) begin
                // RULE_08: interrupt instead of reset
                r_next.irq_flag = 1'b1;
                if (enabled) begin
                    // RULE_21: next time-out resets
                    r_next.watchdog_interrupt_enable_bit = 1'b0;
                end
            end else begin
                // RULE_07: expiry resets the processor
                wdt_fire = 1'b1;
            end
        end

        // ****************************************
        // reset sequencer
        // ****************************************
        case (r_reg.state)
            wdt_pkg::ST_RUN: begin
                if (req) begin
                    r_next.state = wdt_pkg::ST_RESET;
                end else if (wdt_fire) begin
                    r_next.state = wdt_pkg::ST_WDT_PULSE;
                end
            end
            wdt_pkg::ST_WDT_PULSE: begin
                // RULE_04: single cycle pulse then delay
                r_next.delay_cnt = '0;
                r_next.state = req ? wdt_pkg::ST_RESET : wdt_pkg::ST_DELAY;
            end
            wdt_pkg::ST_RESET: begin
                // RULE_01: held while any request stands
                r_next.delay_cnt = '0;
                if (!req) begin
                    r_next.state = wdt_pkg::ST_DELAY;
                end
            end
            wdt_pkg::ST_DELAY: begin
                // RULE_02: count the start-up delay
                // RULE_24: static delay input
                if (req) begin
                    r_next.state = wdt_pkg::ST_RESET;
                end else if (({1'b0, r_reg.delay_cnt} + 1'b1) >=
                             {1'b0, startup_delay_period}) begin
                    r_next.state = wdt_pkg::ST_RUN;
                end else begin
                    r_next.delay_cnt = r_reg.delay_cnt + 1'b1;
                end
            end
            default: begin
                r_next.state = wdt_pkg::ST_RESET;
            end
        endcase

        // chip reset returns control registers to initial values
        if (r_reg.state != wdt_pkg::ST_RUN) begin
            r_next.watchdog_interrupt_enable_bit = 1'b0;
            r_next.wde_bit = 1'b0;
            r_next.period = wdt_pkg::PERIOD_RESET;
            r_next.win_cnt = 3'h0;
            r_next.irq_flag = 1'b0;
            r_next.comparator_bandgap_select = 1'b0;
            r_next.adc_en = 1'b0;
        end

        // ****************************************
        // reset cause flags, set wins over clear
        // ****************************************
        // RULE_14: watchdog reset sets its flag
        if (wdt_fire) begin
            r_next.cause[wdt_pkg::CAUSE_WDT] = 1'b1;
        end
        // RULE_16: pin reset sets its flag
        if (lk.pin_req && !r_reg.pin_prev) begin
            r_next.cause[wdt_pkg::CAUSE_PIN] = 1'b1;
        end
        // RULE_15: brown-out reset sets its flag
        if (bod_req && !r_reg.bod_prev) begin
            r_next.cause[wdt_pkg::CAUSE_BOD] = 1'b1;
        end
        r_next.pin_prev = lk.pin_req;
        r_next.bod_prev = bod_req;

        // RULE_19: bandgap enable
        r_next.bandgap = brownout_detector_enable | r_next.comparator_bandgap_select | r_next.adc_en;

        // ****************************************
        // bus address phase and read data
        // ****************************************
        r_next.wr_pend = 1'b0;
        r_next.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[wdt_pkg::TRANS_ACTIVE_BIT]) begin
            r_next.wr_pend = hwrite & (hsize == wdt_pkg::SIZE_WORD);
            r_next.wr_addr = haddr[wdt_pkg::REG_ADDR_W-1:0];
            rd_en = ~hwrite;
        end
        if (rd_en) begin
            if (haddr[7:0] == wdt_pkg::ADDR_RESET_CAUSE) begin
                // RULE_13: upper bits read zero
                r_next.rdata = {28'h0000000, r_next.cause};
            end else if (haddr[7:0] == wdt_pkg::ADDR_WDT_CTRL) begin
                r_next.rdata = {24'h000000,
                                r_next.irq_flag,
                                r_next.watchdog_interrupt_enable_bit,
                                r_next.period[3],
                                (r_next.win_cnt != 3'h0),
                                watchdog_safety_fuse | r_next.cause[wdt_pkg::CAUSE_WDT] |
                                    r_next.wde_bit,
                                r_next.period[2:0]};
            end else if (haddr[7:0] == wdt_pkg::ADDR_ANALOG_REF) begin
                r_next.rdata = {30'h00000000, r_next.adc_en, r_next.comparator_bandgap_select};
            end else begin
                r_next.rdata = 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= CORE_RESET;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign lk.core_reset_req = (r_reg.state != wdt_pkg::ST_RUN);
    assign processor_reset = lk.core_reset;
    assign watchdog_irq = r_reg.irq_flag;
    assign bandgap_enable = r_reg.bandgap;
    assign hreadyout = r_reg.ready;
    assign hrdata = r_reg.rdata;
    assign hresp = 1'b0;

endmodule
`default_nettype wire

// *** verif/watchdog_and_reset_control_sva.sv ***
// port assertions for the reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic reset_pin_n,
    input wire logic pin_reset_enable,
    input wire logic brownout_low,
    input wire logic brownout_detector_enable,
    input wire logic watchdog_safety_fuse,
    input wire logic processor_reset,
    input wire logic bandgap_enable
);
    // ****************************************
    // properties
    // ****************************************
    logic rd_req;
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    a_pin_async: assert property (
        pin_reset_enable && !reset_pin_n |-> processor_reset)
        else $error("pin low without processor reset");
    a_bod_reset: assert property (
        brownout_detector_enable && brownout_low |-> ##[0:4] processor_reset)
        else $error("brown-out without processor reset");
    a_reset_hold: assert property ($rose(processor_reset) |-> processor_reset[*3])
        else $error("processor reset released too early");
    a_rdata_idle: assert property (!rd_req |=> hrdata == 32'h0)
        else $error("read data outside a read");
    a_cause_upper: assert property (
        rd_req && haddr[7:0] == wdt_pkg::ADDR_RESET_CAUSE |=> hrdata[31:4] == 28'h0)
        else $error("cause register upper bits set");
    a_fuse_enable: assert property (
        rd_req && haddr[7:0] == wdt_pkg::ADDR_WDT_CTRL && watchdog_safety_fuse
        |=> hrdata[wdt_pkg::WC_ENABLE])
        else $error("enable reads zero in level two");
    a_bandgap_on: assert property (brownout_detector_enable |=> bandgap_enable)
        else $error("bandgap off with detector on");
endmodule
bind watchdog_and_reset_control wdt_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_pin_n(reset_pin_n),
    .pin_reset_enable(pin_reset_enable), .brownout_low(brownout_low),
    .brownout_detector_enable(brownout_detector_enable),
    .watchdog_safety_fuse(watchdog_safety_fuse), .processor_reset(processor_reset),
    .bandgap_enable(bandgap_enable));
`default_nettype wire

// *** verif/tb_watchdog_and_reset_control.sv ***
// self-checking bench for the reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_and_reset_control;
    localparam int DLY = 4;
    localparam logic [7:0] AC = wdt_pkg::ADDR_RESET_CAUSE;
    localparam logic [7:0] AW = wdt_pkg::ADDR_WDT_CTRL;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, reset_pin_n;
    logic brownout_low, bod_en, osc, fuse, restart, irq_ack, processor_reset, pin_en;
    logic watchdog_irq, bandgap_enable;
    logic [31:0] haddr, hwdata, hrdata, r, cause_m, pv;
    logic [1:0] htrans;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int n, code, bad;
    assign hready = hreadyout;
    watchdog_and_reset_control #(.DELAY_W(4)) dut (.hclk(hclk), .hresetn(hresetn),
        .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(wdt_pkg::SIZE_WORD), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_pin_n(reset_pin_n),
        .pin_reset_enable(pin_en), .brownout_low(brownout_low),
        .brownout_detector_enable(bod_en), .watchdog_osc(osc),
        .watchdog_safety_fuse(fuse), .startup_delay_period(4'h4),
        .watchdog_restart_instruction(restart), .watchdog_irq_ack(irq_ack),
        .processor_reset(processor_reset), .watchdog_irq(watchdog_irq),
        .bandgap_enable(bandgap_enable));
    // ****************************************
    // clocks, tasks and model
    // ****************************************
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        osc = 0;
        forever #20 osc = ~osc;
    end
    task end_sim();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            end_sim();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        if (a == AC) cause_m = cause_m & d;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task wait_low(output int k);
        k = 0;
        while (processor_reset !== 1'b0) begin
            @(posedge hclk);
            k++;
        end
    endtask
    task power_up();
        hresetn <= 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        cause_m = 32'h1;
        wait_low(n);
    endtask
    initial begin
        void'($urandom(32'h360dd5b4));
        hresetn = 0; hsel = 0; haddr = 0; hwrite = 0; htrans = 0; hwdata = 0; pin_en = 1;
        reset_pin_n = 1; brownout_low = 0; bod_en = 0; fuse = 0; restart = 0; irq_ack = 0;
        power_up();
        rd(AC, cause_m);
        rd(AW, 32'h0);
        rd(8'h50, 32'h0);
        wr(AC, 32'hff);
        rd(AC, cause_m);
        wr(AC, 32'h0);
        rd(AC, cause_m);
        for (int v = 0; v < 4; v++) begin
            wr(wdt_pkg::ADDR_ANALOG_REF, v);
            repeat (2) @(posedge hclk);
            chk(bandgap_enable, v != 0);
        end
        repeat (3) begin
            code = $urandom % 10;
            pv = ((code & 8) << 2) | (code & 7);
            wr(AW, pv);
            rd(AW, pv);
        end
        wr(AW, 32'h08);
        wr(AW, 32'h00);
        rd(AW, 32'h08);
        wr(AW, 32'h18);
        wr(AW, 32'h00);
        rd(AW, 32'h00);
        wr(AW, 32'h08);
        wr(AW, 32'h18);
        repeat (8) @(posedge hclk);
        wr(AW, 32'h00);
        rd(AW, 32'h08);
        bad = 0;
        repeat (12) begin
            repeat (700) begin
                @(posedge hclk);
                if (processor_reset !== 1'b0) bad++;
            end
            restart <= 1;
            @(posedge hclk);
            restart <= 0;
        end
        chk(bad, 0);
        n = 0;
        while (processor_reset !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        chk(n > 8180 && n < 8210, 1);
        wait_low(n);
        chk(n >= DLY && n <= DLY + 4, 1);
        cause_m = cause_m | 32'h8;
        rd(AC, cause_m);
        rd(AW, 32'h08);
        wr(AC, 32'h0);
        rd(AW, 32'h00);
        wr(AW, 32'h48);
        while (watchdog_irq !== 1'b1) @(posedge hclk);
        chk(processor_reset, 0);
        rd(AW, 32'h88);
        irq_ack <= 1;
        @(posedge hclk);
        irq_ack <= 0;
        repeat (2) @(posedge hclk);
        chk(watchdog_irq, 0);
        wr(AW, 32'h18);
        wr(AW, 32'h00);
        rd(AW, 32'h00);
        pin_en <= 0;
        reset_pin_n <= 0;
        repeat (3) @(posedge hclk);
        chk(processor_reset, 0);
        pin_en <= 1;
        repeat (3) @(posedge hclk);
        chk(processor_reset, 1);
        reset_pin_n <= 1;
        wait_low(n);
        chk(n > DLY && n <= DLY + 8, 1);
        cause_m = cause_m | 32'h2;
        rd(AC, cause_m);
        bod_en <= 1;
        brownout_low <= 1;
        repeat (5) @(posedge hclk);
        chk(processor_reset, 1);
        brownout_low <= 0;
        wait_low(n);
        chk(n > DLY && n <= DLY + 8, 1);
        cause_m = cause_m | 32'h4;
        rd(AC, cause_m);
        fuse <= 1;
        power_up();
        rd(AC, cause_m);
        rd(AW, 32'h08);
        wr(AW, 32'h18);
        wr(AW, 32'h00);
        rd(AW, 32'h08);
        wr(AW, 32'h09);
        rd(AW, 32'h08);
        wr(AW, 32'h18);
        wr(AW, 32'h01);
        rd(AW, 32'h09);
        end_sim();
    end
endmodule
`default_nettype wire
